// >>> design/gtc_cfg.svh
// offsets, field positions, reset values and timing for the gated timer
`ifndef GTC_CFG_SVH
`define GTC_CFG_SVH

`define GTC_CLK_HZ        40000000
`define GTC_PERIOD_NS     25

`define GTC_OFS_CTRL      8'h00
`define GTC_OFS_OSC       8'h04
`define GTC_OFS_STATUS    8'h08
`define GTC_OFS_COUNT     8'h0C

`define GTC_CTRL_TIMER_ON 0
`define GTC_CTRL_OSC_EN   1
`define GTC_CTRL_GATE_EN  2
`define GTC_CTRL_SRC_LO   3
`define GTC_CTRL_SRC_HI   4
`define GTC_CTRL_PS_LO    5
`define GTC_CTRL_PS_HI    6

`define GTC_OSC_MODE_LO   0
`define GTC_OSC_MODE_HI   2
`define GTC_OSC_CLOCK_OUTPUT_FUNCTION    3

`define GTC_ST_WRAP       0
`define GTC_ST_OSC_RUN    1
`define GTC_ST_EXT_OK     2
`define GTC_ST_LP_OK      3
`define GTC_ST_GATED      4

`define GTC_CTRL_RESET    7'h00
`define GTC_OSC_RESET     4'h0
`define GTC_COUNT_RESET   16'h0000

`endif

// >>> design/gtc_pkg.sv
// types shared by the gated timer
package gtc_pkg;

   // processor oscillator mode, as held in the oscillator register
   typedef enum logic [2:0] {
      GTC_OSC_EXT_CLOCK,
      GTC_OSC_INT_RC,
      GTC_OSC_RC,
      GTC_OSC_LOW_POWER,
      GTC_OSC_CRYSTAL,
      GTC_OSC_HIGH_SPEED
   } gtc_osc_mode_t;

   // count source selected by software
   typedef enum logic [1:0] {
      GTC_SRC_SYSTEM,
      GTC_SRC_EXT_PIN,
      GTC_SRC_LOW_POWER,
      GTC_SRC_NONE
   } gtc_src_t;

endpackage

// >>> design/gtc_timer.sv
// gated timer with prescaler, source selection and APB registers
`timescale 1ns/1ps
`default_nettype none
`include "gtc_cfg.svh"

module gtc_timer (
   // clock and reset
   input  wire logic        pclk,
   input  wire logic        presetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   // count inputs
   input  wire logic        timer_ext_clock_in,
   input  wire logic        count_gate_n,
   input  wire logic        lp_osc_wave,
   input  wire logic        sleep_mode,
   // outputs
   output var  logic        lp_osc_run,
   output var  logic [15:0] count_value,
   output var  logic        count_wrap
);

   // decoded register index, 4 means unmapped
   function automatic logic [2:0] reg_index(input logic [7:0] a);
      case (a)
         `GTC_OFS_CTRL:   reg_index = 3'h0;
         `GTC_OFS_OSC:    reg_index = 3'h1;
         `GTC_OFS_STATUS: reg_index = 3'h2;
         `GTC_OFS_COUNT:  reg_index = 3'h3;
         default:         reg_index = 3'h4;
      endcase
   endfunction

   logic [6:0]  ctrl;
   logic [3:0]  osc_cfg;
   logic        wrap_flag;
   logic [2:0]  pre_cnt;
   logic        ext_q;
   logic        ext_prev;
   logic        lp_q;
   logic        lp_prev;
   logic        gate_q;
   logic        access;
   logic        done;
   logic        wr_ctrl;
   logic        wr_osc;
   logic        wr_status;
   logic        wr_count;
   logic        timer_on;
   logic        gate_en;
   logic [1:0]  ps_sel;
   logic [2:0]  ps_top;
   logic        clock_output_function_on;
   logic        ext_ok;
   logic        lp_ok;
   logic        gate_open;
   logic        src_tick;
   logic        step;
   logic        pre_wrap;
   logic        next_osc_run;
   logic [31:0] next_rdata;
   gtc_pkg::gtc_osc_mode_t osc_mode;
   gtc_pkg::gtc_src_t      src;

   // apb handshake: one wait state, answer in the second access cycle
   assign access    = psel & penable;
   assign done      = access & pready;
   assign wr_ctrl   = done & pwrite & (reg_index(paddr) == 3'h0);
   assign wr_osc    = done & pwrite & (reg_index(paddr) == 3'h1);
   assign wr_status = done & pwrite & (reg_index(paddr) == 3'h2);
   assign wr_count  = done & pwrite & (reg_index(paddr) == 3'h3);

   // configuration fields
   assign timer_on  = ctrl[`GTC_CTRL_TIMER_ON];
   assign gate_en   = ctrl[`GTC_CTRL_GATE_EN];
   assign ps_sel    = ctrl[`GTC_CTRL_PS_HI:`GTC_CTRL_PS_LO];
   assign src       = gtc_pkg::gtc_src_t'(ctrl[`GTC_CTRL_SRC_HI:`GTC_CTRL_SRC_LO]);
   assign osc_mode  = gtc_pkg::gtc_osc_mode_t'(osc_cfg[`GTC_OSC_MODE_HI:`GTC_OSC_MODE_LO]);
   assign clock_output_function_on = osc_cfg[`GTC_OSC_CLOCK_OUTPUT_FUNCTION];

   // shared pin is free only when the oscillator leaves it alone
   assign ext_ok = (osc_mode == gtc_pkg::GTC_OSC_EXT_CLOCK)
                 | ((osc_mode == gtc_pkg::GTC_OSC_INT_RC) & ~clock_output_function_on)
                 | ((osc_mode == gtc_pkg::GTC_OSC_RC) & ~clock_output_function_on);

   assign lp_ok = (osc_mode == gtc_pkg::GTC_OSC_INT_RC) & ~clock_output_function_on;

   // as system clock the oscillator halts in sleep, else it follows its enable
   always_comb begin
      if (osc_mode == gtc_pkg::GTC_OSC_LOW_POWER) begin
         next_osc_run = ~sleep_mode;
      end else begin
         next_osc_run = ctrl[`GTC_CTRL_OSC_EN];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lp_osc_run <= 1'b0;
      end else begin
         lp_osc_run <= next_osc_run;
      end
   end

   // inputs are synchronous; one stage plus a previous copy for edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ext_q    <= 1'b0;
         ext_prev <= 1'b0;
         lp_q     <= 1'b0;
         lp_prev  <= 1'b0;
         gate_q   <= 1'b1;
      end else begin
         ext_q    <= timer_ext_clock_in;
         ext_prev <= ext_q;
         lp_q     <= lp_osc_wave;
         lp_prev  <= lp_q;
         gate_q   <= count_gate_n;
      end
   end

   // rising edge of the selected count clock
   always_comb begin
      case (src)
         gtc_pkg::GTC_SRC_SYSTEM:    src_tick = 1'b1;
         gtc_pkg::GTC_SRC_EXT_PIN:   src_tick = ext_ok & ext_q & ~ext_prev;
         gtc_pkg::GTC_SRC_LOW_POWER: src_tick = lp_ok & lp_osc_run & lp_q & ~lp_prev;
         default:                    src_tick = 1'b0;
      endcase
   end

   // gate ignored when gating is off; a high gate blocks the tick
   assign gate_open = ~gate_en | ~gate_q;
   // gating before the prescaler stops both stages together
   assign step      = timer_on & src_tick & gate_open;

   // prescale ratio 1, 2, 4 or 8
   assign ps_top   = 3'((4'h1 << ps_sel) - 4'h1);
   assign pre_wrap = step & (pre_cnt >= ps_top);

   // prescaler holds its value while gated, never cleared by the gate
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_cnt <= 3'h0;
      end else if (wr_count) begin
         pre_cnt <= 3'h0;
      end else if (pre_wrap) begin
         pre_cnt <= 3'h0;
      end else if (step) begin
         pre_cnt <= pre_cnt + 3'h1;
      end
   end

   // counter: software load wins, otherwise advance on prescaler wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_value <= `GTC_COUNT_RESET;
      end else if (wr_count) begin
         count_value <= pwdata[15:0];
      end else if (pre_wrap) begin
         count_value <= count_value + 16'h0001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_wrap <= 1'b0;
      end else begin
         count_wrap <= pre_wrap & ~wr_count & (count_value == 16'hFFFF);
      end
   end

   // sticky wrap flag, write one to clear; a new wrap beats the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wrap_flag <= 1'b0;
      end else if (count_wrap) begin
         wrap_flag <= 1'b1;
      end else if (wr_status & pwdata[`GTC_ST_WRAP]) begin
         wrap_flag <= 1'b0;
      end
   end

   // configuration registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= `GTC_CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl <= pwdata[6:0];
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         osc_cfg <= `GTC_OSC_RESET;
      end else if (wr_osc) begin
         osc_cfg <= pwdata[3:0];
      end
   end

   // read mux
   always_comb begin
      next_rdata = 32'h0000_0000;
      case (reg_index(paddr))
         3'h0: next_rdata[6:0] = ctrl;
         3'h1: next_rdata[3:0] = osc_cfg;
         3'h2: begin
            next_rdata[`GTC_ST_WRAP]    = wrap_flag;
            next_rdata[`GTC_ST_OSC_RUN] = lp_osc_run;
            next_rdata[`GTC_ST_EXT_OK]  = ext_ok;
            next_rdata[`GTC_ST_LP_OK]   = lp_ok;
            next_rdata[`GTC_ST_GATED]   = ~gate_open;
         end
         3'h3: next_rdata[15:0] = count_value;
         default: next_rdata = 32'h0000_0000;
      endcase
   end

   // answer registered so all bus outputs come from flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0000_0000;
      end else begin
         pready  <= access & ~pready;
         pslverr <= access & ~pready & (reg_index(paddr) == 3'h4);
         prdata  <= (access & ~pready & ~pwrite) ? next_rdata : 32'h0000_0000;
      end
   end

   // checks

   a_gate_holds_count: assert property (@(posedge pclk) disable iff (!presetn)
      (gate_en && gate_q && !wr_count) |=> ($stable(count_value) && $stable(pre_cnt)))
      else $error("count moved while gate held it");

   a_gate_stops_step: assert property (@(posedge pclk) disable iff (!presetn)
      (gate_en && gate_q) |-> !step)
      else $error("step taken with gate closed");

   a_open_gate_counts: assert property (@(posedge pclk) disable iff (!presetn)
      (timer_on && !gate_en && src == gtc_pkg::GTC_SRC_SYSTEM && ps_sel == 2'h0
       && !wr_count) |=> (count_value == $past(count_value) + 16'h0001))
      else $error("open gate did not count");

   a_ungated_ignores_pin: assert property (@(posedge pclk) disable iff (!presetn)
      (!gate_en && timer_on && src_tick) |-> step)
      else $error("gate pin acted with gating off");

   // mode list written out again so a slip in the availability decode shows up
   a_ext_only_free_pin: assert property (@(posedge pclk) disable iff (!presetn)
      (step && src == gtc_pkg::GTC_SRC_EXT_PIN) |->
      ((osc_mode == gtc_pkg::GTC_OSC_EXT_CLOCK)
       || ((osc_mode == gtc_pkg::GTC_OSC_INT_RC || osc_mode == gtc_pkg::GTC_OSC_RC)
           && !clock_output_function_on)))
      else $error("external clock used in wrong mode");

   a_lp_needs_rc: assert property (@(posedge pclk) disable iff (!presetn)
      (step && src == gtc_pkg::GTC_SRC_LOW_POWER) |->
      (osc_mode == gtc_pkg::GTC_OSC_INT_RC && !clock_output_function_on))
      else $error("low-power source outside internal RC mode");

   a_osc_sleep_halt: assert property (@(posedge pclk) disable iff (!presetn)
      (osc_mode == gtc_pkg::GTC_OSC_LOW_POWER && sleep_mode) |=> !lp_osc_run)
      else $error("system oscillator ran in sleep");

   a_osc_keeps_running: assert property (@(posedge pclk) disable iff (!presetn)
      (ctrl[`GTC_CTRL_OSC_EN] && osc_mode != gtc_pkg::GTC_OSC_LOW_POWER)
      |=> lp_osc_run)
      else $error("enabled oscillator stopped");

   a_prescale_ratio: assert property (@(posedge pclk) disable iff (!presetn)
      (step && !wr_count && ps_sel == 2'h3 && pre_cnt != 3'h7)
      |=> (pre_cnt == $past(pre_cnt) + 3'h1 && $stable(count_value)))
      else $error("prescaler divided by wrong ratio");

   a_apb_one_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pready) |=> pready ##1 !pready)
      else $error("apb answer timing wrong");

   // bus refusal and idle answer
   a_unmapped_error: assert property (@(posedge pclk) disable iff (!presetn)
      (access && !pready && reg_index(paddr) == 3'h4) |=> (pready && pslverr))
      else $error("unmapped access not refused");

   a_answer_quiet: assert property (@(posedge pclk) disable iff (!presetn)
      !pready |-> (prdata == 32'h0000_0000 && !pslverr))
      else $error("bus answer outside ready");

   // counting, loading and wrap
   a_prescale_holds: assert property (@(posedge pclk) disable iff (!presetn)
      (!step && !wr_count) |=> $stable(pre_cnt))
      else $error("prescaler moved without a step");

   a_ext_edge_counts: assert property (@(posedge pclk) disable iff (!presetn)
      (timer_on && !gate_en && src == gtc_pkg::GTC_SRC_EXT_PIN && ext_ok
       && ps_sel == 2'h0 && ext_q && !ext_prev && !wr_count)
      |=> (count_value == $past(count_value) + 16'h0001))
      else $error("external edge not counted");

   a_lp_clock_output_function_blocks: assert property (@(posedge pclk) disable iff (!presetn)
      (src == gtc_pkg::GTC_SRC_LOW_POWER && clock_output_function_on && !wr_count) |=> $stable(count_value))
      else $error("low-power source counted with clock output on");

   a_load_wins: assert property (@(posedge pclk) disable iff (!presetn)
      wr_count |=> (count_value == $past(pwdata[15:0])))
      else $error("count load lost");

   a_wrap_one_pulse: assert property (@(posedge pclk) disable iff (!presetn)
      count_wrap |=> !count_wrap)
      else $error("wrap pulse stretched");

   a_wrap_sets_flag: assert property (@(posedge pclk) disable iff (!presetn)
      count_wrap |=> wrap_flag)
      else $error("wrap flag not set");

   // oscillator run control
   a_lp_runs_asleep: assert property (@(posedge pclk) disable iff (!presetn)
      (src == gtc_pkg::GTC_SRC_LOW_POWER && lp_ok && ctrl[`GTC_CTRL_OSC_EN] && sleep_mode)
      |=> lp_osc_run)
      else $error("timer oscillator stopped in sleep");

   a_osc_idle_off: assert property (@(posedge pclk) disable iff (!presetn)
      (!ctrl[`GTC_CTRL_OSC_EN] && osc_mode != gtc_pkg::GTC_OSC_LOW_POWER) |=> !lp_osc_run)
      else $error("oscillator ran without enable");

   c_gated_hold: cover property (@(posedge pclk) disable iff (!presetn)
      gate_en && gate_q && timer_on ##1 gate_en && !gate_q && step);

   c_ext_count: cover property (@(posedge pclk) disable iff (!presetn)
      step && src == gtc_pkg::GTC_SRC_EXT_PIN);

   c_lp_in_sleep: cover property (@(posedge pclk) disable iff (!presetn)
      step && src == gtc_pkg::GTC_SRC_LOW_POWER && sleep_mode);

   c_wrap: cover property (@(posedge pclk) disable iff (!presetn) count_wrap);

   c_prescale_wrap: cover property (@(posedge pclk) disable iff (!presetn)
      pre_wrap && ps_sel == 2'h3);

endmodule
`default_nettype wire

// >>> dv/gtc_partner.sv
// external count clock, low-power oscillator wave and gate source
`timescale 1ns/1ps
`default_nettype none

module gtc_partner #(
   parameter int HALF = 2
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // bench control
   input  wire logic ext_run,
   input  wire logic gate_req_n,
   // from the timer
   input  wire logic lp_osc_run,
   // to the timer
   output var  logic timer_ext_clock_in,
   output var  logic lp_osc_wave,
   output var  logic count_gate_n
);
   logic [3:0] div;
   logic [1:0] lpd;
   logic       fall;

   // period 2*HALF pclk keeps the external clock below pclk/2
   assign fall = ext_run && timer_ext_clock_in && (div == HALF - 1);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         div <= 4'h0;
         timer_ext_clock_in <= 1'b0;
      end else if (!ext_run) begin
         div <= 4'h0;
         timer_ext_clock_in <= 1'b0; // still between bursts
      end else if (div == HALF - 1) begin
         div <= 4'h0;
         timer_ext_clock_in <= ~timer_ext_clock_in;
      end else begin
         div <= div + 4'h1;
      end
   end

   // oscillator swings only while the timer lets it run
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lpd <= 2'h0;
         lp_osc_wave <= 1'b0;
      end else if (lp_osc_run) begin
         lpd <= lpd + 2'h1;
         if (lpd == 2'h3) begin
            lp_osc_wave <= ~lp_osc_wave;
         end
      end
   end

   // gate moves with the falling count edge when the pin clock runs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_gate_n <= 1'b1;
      end else if (!ext_run || fall) begin
         count_gate_n <= gate_req_n;
      end
   end
endmodule
`default_nettype wire

// >>> dv/testbench.sv
// self-checking bench for the gated timer
`timescale 1ns/1ps
`default_nettype none
`include "gtc_cfg.svh"

module testbench;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic        ext_run = 1'b0;
   logic        gate_req_n = 1'b1;
   logic        sleep_mode = 1'b0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        timer_ext_clock_in;
   logic        lp_osc_wave;
   logic        count_gate_n;
   logic        lp_osc_run;
   logic        count_wrap;
   logic [15:0] count_value;
   logic [31:0] rd;
   logic        er;
   int          mismatches = 0;
   int          num_checks = 0;

   always #12.5 pclk = ~pclk;

   gtc_timer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .timer_ext_clock_in(timer_ext_clock_in),
      .count_gate_n(count_gate_n), .lp_osc_wave(lp_osc_wave), .sleep_mode(sleep_mode),
      .lp_osc_run(lp_osc_run), .count_value(count_value), .count_wrap(count_wrap));

   gtc_partner #(.HALF(2)) far_side (.pclk(pclk), .presetn(presetn), .ext_run(ext_run),
      .gate_req_n(gate_req_n), .lp_osc_run(lp_osc_run),
      .timer_ext_clock_in(timer_ext_clock_in), .lp_osc_wave(lp_osc_wave),
      .count_gate_n(count_gate_n));

   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string msg);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH at %0t: %s got %h expected %h", $time, msg, got, exp);
      end
   endtask

   // one transfer; the master waits up to 20 cycles for pready, then fails with a timeout
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) begin
         check(0, 1, "apb timeout");
         give_verdict();
      end
   endtask

   // counts gained over cyc cycles, after the sample pipeline settles
   task automatic delta(input int cyc, input logic [15:0] exp, input string msg);
      logic [15:0] c0;
      logic [15:0] dd;
      repeat (4) @(posedge pclk);
      #1 c0 = count_value;
      repeat (cyc) @(posedge pclk);
      #1 dd = count_value - c0;
      check({16'h0000, dd}, {16'h0000, exp}, msg);
   endtask

   task automatic t_reset();
      apb(1'b0, `GTC_OFS_CTRL, 32'h0);
      check(rd, 32'h00000000, "ctrl reset");
      apb(1'b0, `GTC_OFS_COUNT, 32'h0);
      check(rd, 32'h00000000, "count reset");
      apb(1'b0, 8'h10, 32'h0);
      check({31'h0, er}, 32'h00000001, "unmapped error");
   endtask

   task automatic t_gate();
      apb(1'b1, `GTC_OFS_CTRL, 32'h00000005);
      delta(20, 16'h0000, "gate closed holds");
      gate_req_n <= 1'b0;
      delta(20, 16'h0014, "gate open counts");
      apb(1'b1, `GTC_OFS_CTRL, 32'h00000001);
      gate_req_n <= 1'b1;
      delta(20, 16'h0014, "gate ignored when off");
   endtask

   // prescaler must keep its phase across a closed gate
   task automatic t_prescale();
      apb(1'b1, `GTC_OFS_CTRL, 32'h00000065);
      apb(1'b1, `GTC_OFS_COUNT, 32'h0);
      for (int k = 0; k < 2; k++) begin
         gate_req_n <= 1'b0;
         repeat (4) @(posedge pclk);
         gate_req_n <= 1'b1;
         repeat (8) @(posedge pclk);
         #1 check({16'h0, count_value}, k, "prescaled hold");
      end
   endtask

   task automatic t_ext();
      apb(1'b1, `GTC_OFS_CTRL, 32'h00000009);
      ext_run <= 1'b1;
      for (int m = 0; m < 7; m++) begin
         apb(1'b1, `GTC_OFS_OSC, (m == 6) ? 32'h00000009 : m);
         delta(40, (m < 3) ? 16'h000A : 16'h0000, "pin source");
         apb(1'b0, `GTC_OFS_STATUS, 32'h0);
         check((rd >> 2) & 1, (m < 3) ? 1 : 0, "pin available");
      end
      ext_run <= 1'b0;
   endtask

   task automatic t_lp();
      apb(1'b1, `GTC_OFS_OSC, 32'h00000001);
      apb(1'b1, `GTC_OFS_CTRL, 32'h00000013);
      delta(80, 16'h000A, "osc source");
      @(posedge pclk);
      sleep_mode <= 1'b1;
      delta(80, 16'h000A, "osc in sleep");
      apb(1'b1, `GTC_OFS_OSC, 32'h00000009);
      delta(80, 16'h0000, "osc with clock out");
      apb(1'b1, `GTC_OFS_OSC, 32'h00000003);
      repeat (3) @(posedge pclk);
      #1 check({31'h0, lp_osc_run}, 0, "system osc sleeps");
      apb(1'b1, `GTC_OFS_OSC, 32'h00000001);
      apb(1'b1, `GTC_OFS_CTRL, 32'h00000002);
      repeat (3) @(posedge pclk);
      #1 check({31'h0, lp_osc_run}, 1, "osc runs timer off");
      @(posedge pclk);
      sleep_mode <= 1'b0;
   endtask

   task automatic t_wrap();
      int n;
      n = 0;
      apb(1'b1, `GTC_OFS_OSC, 32'h0);
      apb(1'b1, `GTC_OFS_COUNT, 32'h0000FFF0);
      apb(1'b1, `GTC_OFS_CTRL, 32'h00000001);
      while (count_wrap !== 1'b1 && n < 60) begin
         @(posedge pclk);
         #1 n++;
      end
      if (n >= 60) begin
         check(0, 1, "wrap timeout");
         give_verdict();
      end
      // pulse rises with the edge that takes the count to zero
      check({16'h0, count_value}, 32'h00000000, "wrap pulse");
      @(posedge pclk);
      #1 check({31'h0, count_wrap}, 32'h00000000, "wrap pulse ends");
      apb(1'b0, `GTC_OFS_STATUS, 32'h0);
      check(rd & 1, 1, "wrap sticky");
      apb(1'b1, `GTC_OFS_STATUS, 32'h00000001);
      apb(1'b0, `GTC_OFS_STATUS, 32'h0);
      check(rd & 1, 0, "wrap cleared");
   endtask

   // reset in mid-run with the counter busy restores the count, osc run and ctrl reset values
   task automatic t_midreset();
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      #1 check({16'h0, count_value}, 32'h00000000, "count held in reset");
      check({31'h0, lp_osc_run}, 32'h00000000, "osc run in reset");
      @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, `GTC_OFS_CTRL, 32'h0);
      check(rd, 32'h00000000, "ctrl after reset");
      apb(1'b0, `GTC_OFS_COUNT, 32'h0);
      check(rd, 32'h00000000, "count idle after reset");
   endtask

   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_gate();
      t_prescale();
      t_ext();
      t_lp();
      t_wrap();
      t_midreset();
      give_verdict();
   end
endmodule
`default_nettype wire
